// File: rtl/scgen_defines.svh
// Offsets, field positions, reset values and encodings of the special cycle generator.
// Assumes inclusion by bare name from rtl/.
`ifndef SCGEN_DEFINES_SVH
`define SCGEN_DEFINES_SVH
`define SCGEN_OFF_ADDR 12'h000
`define SCGEN_OFF_CTL 12'h004
`define SCGEN_OFF_MASK 12'h008
`define SCGEN_OFF_CMP 12'h00C
`define SCGEN_OFF_SWP 12'h010
`define SCGEN_OFF_MAST 12'h014
`define SCGEN_CTL_TYPE_LO 0
`define SCGEN_CTL_SPACE 2
`define SCGEN_MAST_HOLD 0
`define SCGEN_MAST_ACK 1
`define SCGEN_TYPE_OFF 2'h0
`define SCGEN_TYPE_RMW 2'h1
`define SCGEN_TYPE_LOCK 2'h2
`define SCGEN_SP_A16 3'h0
`define SCGEN_SP_A24 3'h1
`define SCGEN_SP_A32 3'h2
`define SCGEN_W8 2'h0
`define SCGEN_W16 2'h1
`define SCGEN_W32 2'h2
`define SCGEN_RST_WORD 32'h0000_0000
`endif

// File: rtl/scgen_pkg.sv
// Types of the special cycle generator.
// Assumes the defines header is available.
package scgen_pkg;
    // PCI target request, one per data phase
    typedef struct packed {
        logic [31:0] addr;
        logic io_space;
        logic write;
        logic [3:0] byte_en_n;
        logic [31:0] wdata;
    } scgen_preq_type;
    // Image attributes of the covering target image
    typedef struct packed {
        logic [2:0] space;
        logic [1:0] max_width;
        logic posted_wr_en;
        logic [5:0] am_code;
    } scgen_image_type;
    // VMEbus master request
    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am_code;
        logic [1:0] width;
        logic write;
        logic addr_only;
        logic [31:0] wdata;
    } scgen_vreq_type;
    typedef enum logic [5:0] {
        SCGEN_IDLE = 6'b000001,
        SCGEN_RD = 6'b000010,
        SCGEN_WR = 6'b000100,
        SCGEN_LOCK = 6'b001000,
        SCGEN_DONE = 6'b010000,
        SCGEN_ABORT = 6'b100000
    } scgen_state_type;
endpackage

// File: rtl/scgen_top.sv
// Special cycle generator for the PCI target channel: RMW and lock cycles.
// Assumes a PCI target front end giving single-beat requests, and a VMEbus master engine.
`timescale 1ns/100ps
`default_nettype none
`include "scgen_defines.svh"

// Behaviour
// RULE1 - trigger only on address and space match
// RULE2 - no ACK64 on special address match
// RULE3 - VME attributes from covering target image
// RULE4 - type field: off, RMW, lock
// RULE5 - RMW read gives one read, one write
// RULE6 - hold PCI read, return read data
// RULE7 - RMW width follows PCI read width
// RULE8 - swap masked bits that compare true
// RULE9 - RMW-mode writes pass as normal writes
// RULE10 - single beat, no packing during RMW
// RULE11 - only 8, aligned 16, aligned 32
// RULE12 - size within image maximum data width
// RULE13 - RMW only in A16, A24, A32
// RULE14 - illegal RMW read gets Target-Abort
// RULE15 - lock write makes coupled address-only cycle
// RULE16 - lock-mode reads normal, write data dropped
// RULE17 - lock AM code from target image
// RULE18 - hold bit keeps sole bus ownership
// RULE19 - software sets hold, waits acknowledge, clears
// RULE20 - software clears hold after bus error
// RULE21 - ignore byte enables, posted writes disabled
// RULE22 - lock outside A16/A24/A32 becomes regular
module scgen_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // PCI target request side
    input wire logic preq_valid,
    input wire scgen_pkg::scgen_preq_type preq,
    input wire scgen_pkg::scgen_image_type image,
    output logic preq_hit,
    output logic ack64_inhibit,
    output logic preq_bypass,
    output logic preq_done,
    output logic preq_abort,
    output logic [31:0] preq_rdata,
    // VMEbus master side
    output logic vreq_valid,
    output scgen_pkg::scgen_vreq_type vreq,
    input wire logic vreq_done,
    input wire logic vreq_berr,
    input wire logic [31:0] vreq_rdata,
    input wire logic bus_owned,
    output logic hold_bus_ownership
);
    import scgen_pkg::*;

    logic [31:0] special_cycle_address_reg;
    logic [31:0] special_cycle_control_reg;
    logic [31:0] rmw_bit_mask_reg;
    logic [31:0] rmw_compare_data_reg;
    logic [31:0] rmw_swap_data_reg;
    logic hold_reg;
    logic ack_reg;
    scgen_state_type state_reg;
    scgen_state_type state_next;
    scgen_vreq_type vreq_reg;
    logic [31:0] rdata_reg;
    logic [1:0] special_cycle_type;
    logic pci_space_select;
    logic apb_wr;
    logic addr_hit;
    logic space_ok;
    logic size_ok;
    logic width_ok;
    logic width_fits;
    logic [1:0] req_width;
    logic [31:0] merged;

    // Register field views
    assign special_cycle_type = special_cycle_control_reg[`SCGEN_CTL_TYPE_LO +: 2];
    assign pci_space_select = special_cycle_control_reg[`SCGEN_CTL_SPACE];
    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // APB register writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            special_cycle_address_reg <= `SCGEN_RST_WORD;
            special_cycle_control_reg <= `SCGEN_RST_WORD;
            rmw_bit_mask_reg <= `SCGEN_RST_WORD;
            rmw_compare_data_reg <= `SCGEN_RST_WORD;
            rmw_swap_data_reg <= `SCGEN_RST_WORD;
            hold_reg <= 1'b0;
        end else if (apb_wr) begin
            unique case (paddr)
                `SCGEN_OFF_ADDR: special_cycle_address_reg <= pwdata;
                `SCGEN_OFF_CTL: special_cycle_control_reg <= {29'h0000_0000, pwdata[2:0]};
                `SCGEN_OFF_MASK: rmw_bit_mask_reg <= pwdata;
                `SCGEN_OFF_CMP: rmw_compare_data_reg <= pwdata;
                `SCGEN_OFF_SWP: rmw_swap_data_reg <= pwdata;
                `SCGEN_OFF_MAST: hold_reg <= pwdata[`SCGEN_MAST_HOLD];
                default: ;
            endcase
        end
    end

    // Ownership acknowledge follows hold once the bus is owned
    // RULE18 sole ownership hold
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= hold_reg && bus_owned;
        end
    end
    assign hold_bus_ownership = hold_reg;

    // APB read mux, unmapped reads as zero
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `SCGEN_OFF_ADDR: prdata = special_cycle_address_reg;
            `SCGEN_OFF_CTL: prdata = special_cycle_control_reg;
            `SCGEN_OFF_MASK: prdata = rmw_bit_mask_reg;
            `SCGEN_OFF_CMP: prdata = rmw_compare_data_reg;
            `SCGEN_OFF_SWP: prdata = rmw_swap_data_reg;
            `SCGEN_OFF_MAST: prdata = {30'h0000_0000, ack_reg, hold_reg};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // RULE1 address and space compare
    assign addr_hit = preq_valid && (special_cycle_type != `SCGEN_TYPE_OFF)
        && (preq.addr == special_cycle_address_reg) && (preq.io_space == pci_space_select);
    // RULE2 no 64-bit acknowledge on hit
    assign ack64_inhibit = preq_valid && (preq.addr == special_cycle_address_reg)
        && (preq.io_space == pci_space_select);
    // RULE13 RULE22 legal VME address spaces
    assign space_ok = (image.space == `SCGEN_SP_A16) || (image.space == `SCGEN_SP_A24)
        || (image.space == `SCGEN_SP_A32);

    // RULE11 RULE7 width from byte enables
    always_comb begin
        req_width = `SCGEN_W8;
        size_ok = 1'b0;
        unique case (preq.byte_en_n)
            4'hE, 4'hD, 4'hB, 4'h7: begin
                req_width = `SCGEN_W8;
                size_ok = 1'b1;
            end
            4'hC, 4'h3: begin
                req_width = `SCGEN_W16;
                size_ok = 1'b1;
            end
            4'h0: begin
                req_width = `SCGEN_W32;
                size_ok = 1'b1;
            end
            default: begin
                req_width = `SCGEN_W8;
                size_ok = 1'b0;
            end
        endcase
    end
    // RULE12 within image maximum width
    assign width_fits = (req_width <= image.max_width);
    assign width_ok = size_ok && width_fits;

    // RULE8 masked compare and swap
    always_comb begin
        merged = vreq_rdata;
        for (int i = 0; i < 32; i++) begin
            if (rmw_bit_mask_reg[i] && (vreq_rdata[i] == rmw_compare_data_reg[i])) begin
                merged[i] = rmw_swap_data_reg[i];
            end
        end
    end

    // RULE4 mode selection and sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCGEN_IDLE: begin
                if (addr_hit && (special_cycle_type == `SCGEN_TYPE_RMW) && !preq.write) begin
                    // RULE14 abort illegal RMW reads
                    if (width_ok && space_ok) begin
                        state_next = SCGEN_RD;
                    end else begin
                        state_next = SCGEN_ABORT;
                    end
                // RULE21 lock needs posted writes off
                end else if (addr_hit && (special_cycle_type == `SCGEN_TYPE_LOCK) && preq.write
                    && space_ok && !image.posted_wr_en) begin
                    state_next = SCGEN_LOCK;
                end
            end
            SCGEN_RD: begin
                if (vreq_berr) begin
                    state_next = SCGEN_ABORT;
                end else if (vreq_done) begin
                    state_next = SCGEN_WR;
                end
            end
            SCGEN_WR, SCGEN_LOCK: begin
                if (vreq_berr) begin
                    state_next = SCGEN_ABORT;
                end else if (vreq_done) begin
                    state_next = SCGEN_DONE;
                end
            end
            SCGEN_DONE, SCGEN_ABORT: state_next = SCGEN_IDLE;
            default: state_next = SCGEN_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SCGEN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // VME request build, RULE3 RULE17 attributes from image
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vreq_reg <= '0;
        end else if (state_reg == SCGEN_IDLE) begin
            vreq_reg.addr <= preq.addr;
            vreq_reg.am_code <= image.am_code;
            // RULE10 single beat of request width, 32-bit for lock cycles
            vreq_reg.width <= (state_next == SCGEN_LOCK) ? `SCGEN_W32 : req_width;
            vreq_reg.write <= (state_next == SCGEN_LOCK);
            // RULE15 RULE16 address only, data dropped
            vreq_reg.addr_only <= (state_next == SCGEN_LOCK);
            vreq_reg.wdata <= 32'h0000_0000;
        // RULE5 read then one write
        end else if ((state_reg == SCGEN_RD) && vreq_done && !vreq_berr) begin
            vreq_reg.write <= 1'b1;
            vreq_reg.wdata <= merged;
        end
    end
    assign vreq = vreq_reg;
    assign vreq_valid = (state_reg == SCGEN_RD) || (state_reg == SCGEN_WR)
        || (state_reg == SCGEN_LOCK);

    // RULE6 keep read data for the PCI master
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else if ((state_reg == SCGEN_RD) && vreq_done) begin
            rdata_reg <= vreq_rdata;
        end
    end

    // PCI side answers; RULE9 RULE22 others bypass
    assign preq_hit = (state_reg != SCGEN_IDLE) || (state_next != SCGEN_IDLE);
    assign preq_bypass = preq_valid && (state_reg == SCGEN_IDLE) && (state_next == SCGEN_IDLE);
    assign preq_done = (state_reg == SCGEN_DONE);
    assign preq_abort = (state_reg == SCGEN_ABORT);
    assign preq_rdata = rdata_reg;
endmodule // scgen_top
`default_nettype wire

// File: bench/scgen_sva.sv
// Checker of the special cycle generator ports.
// Assumes binding into scgen_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module scgen_sva import scgen_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // PCI side
    input wire logic preq_hit,
    input wire logic ack64_inhibit,
    input wire logic preq_bypass,
    input wire logic preq_done,
    input wire logic preq_abort,
    input wire logic [31:0] preq_rdata,
    // VME side
    input wire logic vreq_valid,
    input wire scgen_pkg::scgen_vreq_type vreq,
    input wire logic vreq_done,
    input wire logic vreq_berr,
    input wire logic [31:0] vreq_rdata
);
    logic [31:0] rd_seen_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Last data returned by a VME read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_seen_reg <= 32'h0000_0000;
        end else if (vreq_valid && !vreq.write && vreq_done) begin
            rd_seen_reg <= vreq_rdata;
        end
    end
    hit_bypass_excl_a:
        assert property (!(preq_hit && preq_bypass)) else $error("hit and bypass together");
    hit_inhibit_a:
        assert property (preq_hit |-> ack64_inhibit) else $error("wide ack not inhibited");
    req_stable_a:
        assert property (vreq_valid && !vreq_done && !vreq_berr |=> vreq_valid && $stable(vreq))
        else $error("VME request changed while pending");
    rd_then_wr_a:
        assert property (vreq_valid && !vreq.write && vreq_done |=> vreq_valid && vreq.write
            && vreq.addr == $past(vreq.addr) && vreq.width == $past(vreq.width)) else $error("no matching write");
    rdata_back_a:
        assert property (preq_done |-> preq_rdata == rd_seen_reg) else $error("wrong read data returned");
    abort_quiet_a:
        assert property (preq_abort |-> !vreq_valid && !preq_done) else $error("abort with VME activity");
    lock_write_a:
        assert property (vreq_valid && vreq.addr_only |-> vreq.write) else $error("address-only read");
    coupled_done_a:
        assert property (vreq_valid && vreq.write && vreq_done |=> preq_done) else $error("write not completed");
    berr_abort_a:
        assert property (vreq_valid && vreq_berr |=> preq_abort) else $error("bus error not aborted");
    cover property (preq_done);
    cover property (preq_abort);
    cover property (vreq_valid && vreq.addr_only && vreq_done);
endmodule // scgen_sva
`default_nettype wire

// File: bench/scgen_vme.sv
// VME slave model: one word of memory, answers after lag cycles.
// Assumes the bench sets lag, berr and preloads via load.
`timescale 1ns/100ps
`default_nettype none
module scgen_vme import scgen_pkg::*; (
    // Clock and bench control
    input wire logic core_clk,
    input wire logic [3:0] lag,
    input wire logic berr,
    input wire logic load,
    input wire logic [31:0] preload,
    // Master side
    input wire logic vreq_valid,
    input wire scgen_pkg::scgen_vreq_type vreq,
    input wire logic hold_bus_ownership,
    output logic vreq_done,
    output logic vreq_berr,
    output logic [31:0] vreq_rdata,
    output logic bus_owned,
    // Observed state
    output logic [31:0] mem,
    output logic [7:0] n_rd,
    output logic [7:0] n_wr,
    output scgen_pkg::scgen_vreq_type last
);
    logic [3:0] cnt;
    // Bus granted while the hold bit stands
    always_ff @(posedge core_clk) begin
        bus_owned <= hold_bus_ownership;
    end
    // One beat after lag cycles; data scrambled when idle
    always_ff @(posedge core_clk) begin
        vreq_done <= 1'h0;
        vreq_berr <= 1'h0;
        vreq_rdata <= ~vreq_rdata;
        if (load) begin
            mem <= preload;
            cnt <= 4'h0;
            n_rd <= 8'h00;
            n_wr <= 8'h00;
        end else if (vreq_valid && !vreq_done && !vreq_berr) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lag) begin
                cnt <= 4'h0;
                last <= vreq;
                vreq_berr <= berr;
                vreq_done <= !berr;
                vreq_rdata <= mem;
                n_rd <= n_rd + 8'(!berr && !vreq.write);
                n_wr <= n_wr + 8'(!berr && vreq.write);
                if (!berr && vreq.write && !vreq.addr_only) begin
                    mem <= vreq.wdata;
                end
            end
        end
    end
endmodule // scgen_vme
`default_nettype wire

// File: bench/test_pci_to_vme_special_cycle_generator.sv
// Self-checking bench: APB setup, PCI requests, VME slave model.
// Assumes scgen_top, scgen_vme and scgen_sva are compiled before.
`timescale 1ns/100ps
`default_nettype none
`include "scgen_defines.svh"
module test_pci_to_vme_special_cycle_generator;
    import scgen_pkg::*;
    localparam logic [31:0] SPA = 32'h0000_1000;
    localparam logic [31:0] PRE = 32'h1234_5678;
    localparam logic [31:0] MSK = 32'h0000_FFFF;
    localparam logic [31:0] CMP = 32'h0000_5600;
    localparam logic [31:0] SWAP_VALUE_FIELD = 32'hABCD_EF01;
    localparam logic [31:0] MRG = (PRE & ~MSK) | (MSK & ~(PRE ^ CMP) & SWAP_VALUE_FIELD) | (MSK & (PRE ^ CMP) & PRE);
    localparam logic [5:0] AM_C = 6'h0D;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, preq_valid, preq_hit, ack64_inhibit;
    logic preq_bypass, preq_done, preq_abort, vreq_valid, vreq_done, vreq_berr, bus_owned;
    logic hold_bus_ownership, berr, load;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, preq_rdata, vreq_rdata, mem, d;
    logic [7:0] n_rd, n_wr;
    logic [3:0] lag;
    scgen_preq_type preq;
    scgen_image_type image;
    scgen_vreq_type vreq, last;
    int err_count, n_compared, n;
    scgen_top uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .preq_valid(preq_valid), .preq(preq), .image(image), .preq_hit(preq_hit), .ack64_inhibit(ack64_inhibit),
        .preq_bypass(preq_bypass), .preq_done(preq_done), .preq_abort(preq_abort), .preq_rdata(preq_rdata),
        .vreq_valid(vreq_valid), .vreq(vreq), .vreq_done(vreq_done), .vreq_berr(vreq_berr),
        .vreq_rdata(vreq_rdata), .bus_owned(bus_owned), .hold_bus_ownership(hold_bus_ownership));
    scgen_vme vme_u (.core_clk(core_clk), .lag(lag), .berr(berr), .load(load), .preload(PRE),
        .vreq_valid(vreq_valid), .vreq(vreq), .hold_bus_ownership(hold_bus_ownership), .vreq_done(vreq_done),
        .vreq_berr(vreq_berr), .vreq_rdata(vreq_rdata), .bus_owned(bus_owned), .mem(mem), .n_rd(n_rd),
        .n_wr(n_wr), .last(last));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask
    // One PCI request; im is space, max width, posted enable
    task automatic step(input logic [2:0] ctl, input logic [3:0] ben, input logic wr, input logic [5:0] im,
        input logic ber, input logic [1:0] er, input logic [1:0] ec, input logic [1:0] ew);
        logic [31:0] r;
        apb(1'h1, `SCGEN_OFF_CTL, {29'h0, ctl}, r);
        berr <= ber;
        lag <= lag + 4'h3;
        load <= 1'h1;
        preq_valid <= 1'h1;
        preq <= {SPA, 1'h0, wr, ben, 32'hA5A5_5A5A};
        image <= {im, AM_C};
        @(posedge core_clk);
        load <= 1'h0;
        chk(32'(ack64_inhibit), 32'(ctl[2] == 1'h0));
        r = 32'h3;
        for (int k = 0; k < 300 && r == 3; k++) begin
            @(posedge core_clk);
            if (preq_done === 1'h1) r = 32'h0;
            else if (preq_abort === 1'h1) r = 32'h1;
            else if (preq_bypass === 1'h1) r = 32'h2;
        end
        preq_valid <= 1'h0;
        @(posedge core_clk);
        chk(r, 32'(er));
        chk({n_rd, n_wr}, {7'h0, ec[1], 7'h0, ec[0]});
        if (er == 0 && ctl[1:0] == 1) begin
            chk(preq_rdata, PRE);
            chk(mem, MRG);
            chk(32'(last.width), 32'(ew));
        end
        if (er == 0 && ctl[1:0] == 2) begin
            chk(mem, PRE);
            chk({last.addr_only, last.am_code}, {1'h1, AM_C});
        end
        $display("test ended at %0t", $time);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, preq_valid, preq, image, berr} = '0;
        {load, lag} = 5'h10;
        repeat (2) @(posedge core_clk);
        nrst <= 1'h1;
        load <= 1'h0;
        for (n = 0; n < 6; n++) begin
            apb(1'h0, 12'(n * 4), '0, d);
            chk(d, 32'h0);
        end
        for (n = 0; n < 4; n++) begin
            apb(1'h1, 12'(n * 4 + (n > 0) * 4), n == 0 ? SPA : n == 1 ? MSK : n == 2 ? CMP : SWAP_VALUE_FIELD, d);
            apb(1'h0, 12'(n * 4 + (n > 0) * 4), '0, d);
            chk(d, n == 0 ? SPA : n == 1 ? MSK : n == 2 ? CMP : SWAP_VALUE_FIELD);
        end
        apb(1'h1, 12'h018, 32'hFFFF_FFFF, d);
        apb(1'h0, 12'h018, '0, d);
        chk(d, 32'h0);
        step(3'h1, 4'h0, 1'h0, 6'h14, 1'h0, 2'h0, 2'h3, `SCGEN_W32);
        step(3'h1, 4'hB, 1'h0, 6'h0C, 1'h0, 2'h0, 2'h3, `SCGEN_W8);
        step(3'h1, 4'hC, 1'h0, 6'h02, 1'h0, 2'h0, 2'h3, `SCGEN_W16);
        step(3'h1, 4'h9, 1'h0, 6'h14, 1'h0, 2'h1, 2'h0, 2'h0);
        step(3'h1, 4'h0, 1'h0, 6'h12, 1'h0, 2'h1, 2'h0, 2'h0);
        step(3'h1, 4'h0, 1'h0, 6'h1C, 1'h0, 2'h1, 2'h0, 2'h0);
        step(3'h1, 4'h0, 1'h1, 6'h14, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h0, 4'h0, 1'h0, 6'h14, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h3, 4'h0, 1'h0, 6'h14, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h5, 4'h0, 1'h0, 6'h14, 1'h0, 2'h2, 2'h0, 2'h0);
        apb(1'h1, `SCGEN_OFF_MAST, 32'h1, d);
        for (n = 0; n < 8 && d[1] !== 1'h1; n++) apb(1'h0, `SCGEN_OFF_MAST, '0, d);
        chk(d, 32'h3);
        step(3'h2, 4'h5, 1'h1, 6'h0C, 1'h0, 2'h0, 2'h1, 2'h0);
        step(3'h2, 4'h0, 1'h0, 6'h14, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h2, 4'h0, 1'h1, 6'h15, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h2, 4'h0, 1'h1, 6'h24, 1'h0, 2'h2, 2'h0, 2'h0);
        step(3'h1, 4'h0, 1'h0, 6'h14, 1'h1, 2'h1, 2'h0, 2'h0);
        apb(1'h1, `SCGEN_OFF_MAST, 32'h0, d);
        for (n = 0; n < 8 && d[1] !== 1'h0; n++) apb(1'h0, `SCGEN_OFF_MAST, '0, d);
        chk(d, 32'h0);
        tally_and_finish();
    end
endmodule // test_pci_to_vme_special_cycle_generator
bind scgen_top scgen_sva chk_u (.core_clk(core_clk), .nrst(nrst), .preq_hit(preq_hit),
    .ack64_inhibit(ack64_inhibit), .preq_bypass(preq_bypass), .preq_done(preq_done), .preq_abort(preq_abort),
    .preq_rdata(preq_rdata), .vreq_valid(vreq_valid), .vreq(vreq), .vreq_done(vreq_done),
    .vreq_berr(vreq_berr), .vreq_rdata(vreq_rdata));
`default_nettype wire
